/* File: design/cpu_status_control.sv */
`timescale 1ns/100ps
`default_nettype none
module cpu_status_control
   import cpu_status_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Core side
   input wire logic [3:0] stack_ptr_i,
   input wire core_event_type core_event_i,
   input wire logic brownout_detect_enable_i,
   input wire logic [IRQ_SOURCES-1:0] irq_pending_i,
   input wire logic [IRQ_SOURCES-1:0] irq_enable_i,
   output logic irq_o,
   output logic [7:0] status_o
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   status_bits_type status;
   status_bits_type next_status;
   logic [31:0] next_dat;
   logic next_ack;
   logic next_irq;
   logic access;
   logic write_take;
   logic stack_avail;
   logic overflow_seen;

   function automatic logic reg_hit(input logic [7:0] adr);
      reg_hit = (adr[7:2] == STATUS_ADDR[7:2]);
   endfunction : reg_hit

   // ----------------------------------------
   // Stack space tracking
   // ----------------------------------------
   stack_space_monitor i_stack_space_monitor (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .stack_ptr_i(stack_ptr_i),
      .device_reset_i(core_event_i.device_reset),
      .space_avail_o(stack_avail),
      .overflow_o(overflow_seen)
   );

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   // One wait state: ack rises the cycle after the request is seen and
   // drops the cycle after, so a held request is not taken in the ack cycle but is taken again the cycle after.
   always_comb begin
      access = wb_cyc_i && wb_stb_i && !wb_ack_o;
      write_take = access && wb_we_i && reg_hit(wb_adr_i) && wb_sel_i[0];
      next_ack = access;
      next_dat = BUS_ZERO;
      if (access && !wb_we_i && reg_hit(wb_adr_i)) begin
         next_dat = {24'h00_0000, 2'b00, status};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= BUS_ZERO;
      end else begin
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end

   // ----------------------------------------
   // Status bits
   // ----------------------------------------
   always_comb begin
      next_status = status;
      next_status.stack_space_flag = stack_avail;
      if (write_take) begin
         // Only the writable lanes take write data
         next_status.global_irq_block = wb_dat_i[POS_GLOBAL_BLOCK];
         next_status.poweron_flag = wb_dat_i[POS_POWERON];
         next_status.brownout_reset_flag = wb_dat_i[POS_BROWNOUT];
      end
      // Hardware events follow the write so they win the cycle
      if (core_event_i.device_reset) begin
         next_status.global_irq_block = 1'b1;
      end
      // With detect off the flag is left alone; software must not trust it
      if (core_event_i.brownout_reset && brownout_detect_enable_i) begin
         next_status.brownout_reset_flag = 1'b0;
      end
      if (core_event_i.watchdog_clear_instr || core_event_i.sleep_instr) begin
         next_status.watchdog_timeout_flag = 1'b1;
      end
      if (core_event_i.watchdog_timeout) begin
         next_status.watchdog_timeout_flag = 1'b0;
      end
      if (core_event_i.watchdog_clear_instr) begin
         next_status.powerdown_flag = 1'b1;
      end
      if (core_event_i.sleep_instr) begin
         next_status.powerdown_flag = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status <= status_bits_type'(STATUS_RESET[5:0]);
         status_o <= STATUS_RESET;
      end else begin
         status <= next_status;
         status_o <= {2'b00, next_status};
      end
   end

   // ----------------------------------------
   // Interrupt gate
   // ----------------------------------------
   always_comb begin
      next_irq = !status.global_irq_block && |(irq_pending_i & irq_enable_i);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= next_irq;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   chk_unimpl_read_zero: assert property (
      (access && !wb_we_i && reg_hit(wb_adr_i))
      |=> (wb_ack_o && wb_dat_o[7:6] == 2'b00 && wb_dat_o[5:0] == $past(status)))
      else $error("status read returned wrong data");

   chk_ack_single_pulse: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack stood for more than one cycle");

   chk_ack_answers_request: assert property (
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("request not answered in one cycle");

   chk_ack_idle_low: assert property (
      !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack raised with no request");

   chk_nonread_data_zero: assert property (
      (access && (wb_we_i || !reg_hit(wb_adr_i))) |=> (wb_dat_o == BUS_ZERO))
      else $error("write or unmapped read returned data");

   chk_read_upper_zero: assert property (
      wb_ack_o |-> (wb_dat_o[31:6] == 26'h000_0000))
      else $error("read data above the register not zero");

   // ----------------------------------------
   // Stack flag checks
   // ----------------------------------------

   chk_stack_full_clear: assert property (
      (stack_ptr_i == STACK_PTR_FULL) |=> !status_o[POS_STACK_SPACE])
      else $error("stack flag high with full pointer");

   chk_stack_sticky: assert property (
      (overflow_seen && !core_event_i.device_reset)
      |=> (!status_o[POS_STACK_SPACE] && !status.stack_space_flag))
      else $error("stack flag recovered without device reset");

   // Reset hides a wrap: the pointer history restarts with it
   chk_stack_wrap_clear: assert property (
      (!rst_i && !$past(rst_i) && stack_ptr_i == STACK_PTR_WRAP
       && $past(stack_ptr_i) == STACK_PTR_FULL) |=> !status_o[POS_STACK_SPACE])
      else $error("stack flag high after pointer wrap");

   chk_stack_avail_set: assert property (
      (!overflow_seen && stack_ptr_i != STACK_PTR_FULL && stack_ptr_i != STACK_PTR_WRAP)
      |=> status_o[POS_STACK_SPACE])
      else $error("stack flag low with space left");

   chk_stack_reset_rearm: assert property (
      core_event_i.device_reset
      ##1 (stack_ptr_i != STACK_PTR_FULL && stack_ptr_i != STACK_PTR_WRAP)
      |=> status_o[POS_STACK_SPACE])
      else $error("device reset did not re-arm the stack flag");

   // ----------------------------------------
   // Interrupt checks
   // ----------------------------------------

   chk_irq_blocked: assert property (
      status.global_irq_block |=> !irq_o)
      else $error("interrupt passed while globally blocked");

   chk_irq_passed: assert property (
      (!status.global_irq_block && |(irq_pending_i & irq_enable_i)) |=> irq_o)
      else $error("enabled interrupt not raised");

   chk_irq_needs_enable: assert property (
      !(|(irq_pending_i & irq_enable_i)) |=> !irq_o)
      else $error("interrupt raised with no enabled source");

   // ----------------------------------------
   // Status flag checks
   // ----------------------------------------

   chk_timeout_clear: assert property (
      core_event_i.watchdog_timeout |=> !status_o[POS_TIMEOUT])
      else $error("timeout flag not cleared by watchdog timeout");

   chk_timeout_set: assert property (
      ((core_event_i.watchdog_clear_instr || core_event_i.sleep_instr)
       && !core_event_i.watchdog_timeout) |=> status_o[POS_TIMEOUT])
      else $error("timeout flag not set by clear or sleep");

   chk_powerdown_flag: assert property (
      core_event_i.sleep_instr |=> !status_o[POS_POWERDOWN])
      else $error("power-down flag not cleared by sleep");

   chk_powerdown_set: assert property (
      (core_event_i.watchdog_clear_instr && !core_event_i.sleep_instr)
      |=> status_o[POS_POWERDOWN])
      else $error("power-down flag not set by watchdog clear");

   chk_powerdown_hold: assert property (
      (!core_event_i.watchdog_clear_instr && !core_event_i.sleep_instr)
      |=> (status_o[POS_POWERDOWN] == $past(status_o[POS_POWERDOWN])))
      else $error("power-down flag moved without cause");

   chk_timeout_hold: assert property (
      (!core_event_i.watchdog_clear_instr && !core_event_i.sleep_instr
       && !core_event_i.watchdog_timeout)
      |=> (status_o[POS_TIMEOUT] == $past(status_o[POS_TIMEOUT])))
      else $error("timeout flag moved without cause");

   chk_poweron_reset: assert property (
      @(posedge clk_i) disable iff (1'b0)
      rst_i |=> (status_o == STATUS_RESET && !status.poweron_flag))
      else $error("power-on reset value wrong");

   chk_brownout_clear: assert property (
      (core_event_i.brownout_reset && brownout_detect_enable_i)
      |=> !status_o[POS_BROWNOUT])
      else $error("brown-out flag not cleared");

   chk_readonly_bits: assert property (
      (write_take && !core_event_i.watchdog_clear_instr && !core_event_i.sleep_instr
       && !core_event_i.watchdog_timeout)
      |=> (status_o[3:2] == $past(status_o[3:2])))
      else $error("write changed a read-only flag");

   chk_write_takes: assert property (
      (write_take && !core_event_i.device_reset)
      |=> (status_o[POS_GLOBAL_BLOCK] == $past(wb_dat_i[POS_GLOBAL_BLOCK])
           && status_o[POS_POWERON] == $past(wb_dat_i[POS_POWERON])))
      else $error("writable bit did not take write data");

   chk_event_beats_write: assert property (
      (write_take && core_event_i.device_reset) |=> status_o[POS_GLOBAL_BLOCK])
      else $error("write overrode device reset");

   chk_block_device_reset: assert property (
      core_event_i.device_reset |=> status_o[POS_GLOBAL_BLOCK])
      else $error("device reset left interrupts unblocked");

   // A pin or watchdog reset is not a power-on reset, so the cause flags stay
   chk_device_reset_keeps: assert property (
      (core_event_i.device_reset && !write_take && !core_event_i.watchdog_clear_instr
       && !core_event_i.sleep_instr && !core_event_i.watchdog_timeout
       && !core_event_i.brownout_reset)
      |=> (status_o[3:0] == $past(status_o[3:0])))
      else $error("device reset changed a status flag");

   chk_poweron_hold: assert property (
      !write_take |=> (status_o[POS_POWERON] == $past(status_o[POS_POWERON])))
      else $error("power-on flag moved without a write");

   chk_brownout_hold: assert property (
      (!write_take && !(core_event_i.brownout_reset && brownout_detect_enable_i))
      |=> (status_o[POS_BROWNOUT] == $past(status_o[POS_BROWNOUT])))
      else $error("brown-out flag moved without cause");

   chk_brownout_beats_write: assert property (
      (write_take && core_event_i.brownout_reset && brownout_detect_enable_i)
      |=> !status_o[POS_BROWNOUT])
      else $error("write overrode brown-out reset");

   chk_block_hold: assert property (
      (!write_take && !core_event_i.device_reset)
      |=> (status_o[POS_GLOBAL_BLOCK] == $past(status_o[POS_GLOBAL_BLOCK])))
      else $error("global block bit moved without cause");

   // Unmapped or lane-0-less writes must leave the writable bits alone
   chk_ignored_write_kept: assert property (
      (access && wb_we_i && !(reg_hit(wb_adr_i) && wb_sel_i[0])
       && !core_event_i.device_reset)
      |=> (status_o[POS_POWERON] == $past(status_o[POS_POWERON])
           && status_o[POS_GLOBAL_BLOCK] == $past(status_o[POS_GLOBAL_BLOCK])))
      else $error("ignored write changed a writable bit");

endmodule : cpu_status_control
`default_nettype wire

/* File: include/cpu_status_pkg.sv */
// What this block does
// - The status register answers at word index 06h with no bank select, and bits 7-6 read 0.
// - The stack flag is low while the 4-bit stack pointer is Fh or has just wrapped Fh to 0h.
// - After a stack overflow the stack flag stays low until a device reset.
// - A set global block bit stops every interrupt; a clear one passes only enabled sources.
// - The timeout flag is set at power-up, by watchdog clear or sleep, cleared by a timeout.
// - The power-down flag is set at power-up and by watchdog clear, cleared by sleep.
// - A power-on reset clears the power-on flag until software writes it to 1.
// - With brown-out detect on, a brown-out reset clears its flag until software sets it.
// - Writes do not change the stack, timeout and power-down flags.
// - Power-on reset loads bits 5..0 as 111101; only bits 4, 1 and 0 are writable.
package cpu_status_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam int unsigned STATUS_INDEX = 6;
   localparam logic [7:0] STATUS_ADDR = 8'(STATUS_INDEX * 4);
   localparam logic [7:0] STATUS_RESET = 8'h3D;
   localparam logic [7:0] STATUS_WRITE_MASK = 8'h13;
   localparam logic [31:0] BUS_ZERO = 32'h0000_0000;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int unsigned POS_STACK_SPACE = 5;
   localparam int unsigned POS_GLOBAL_BLOCK = 4;
   localparam int unsigned POS_TIMEOUT = 3;
   localparam int unsigned POS_POWERDOWN = 2;
   localparam int unsigned POS_POWERON = 1;
   localparam int unsigned POS_BROWNOUT = 0;

   // ----------------------------------------
   // Stack pointer and interrupt sources
   // ----------------------------------------
   localparam logic [3:0] STACK_PTR_FULL = 4'hF;
   localparam logic [3:0] STACK_PTR_WRAP = 4'h0;
   localparam int unsigned IRQ_SOURCES = 8;

   // Field order matches bit positions 5 down to 0
   typedef struct packed {
      logic stack_space_flag;
      logic global_irq_block;
      logic watchdog_timeout_flag;
      logic powerdown_flag;
      logic poweron_flag;
      logic brownout_reset_flag;
   } status_bits_type;

   // One-cycle pulses from the core and the reset controller
   typedef struct packed {
      logic watchdog_clear_instr;
      logic sleep_instr;
      logic watchdog_timeout;
      logic device_reset;
      logic brownout_reset;
   } core_event_type;

endpackage : cpu_status_pkg

/* File: design/stack_space_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module stack_space_monitor
   import cpu_status_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] stack_ptr_i,
   input wire logic device_reset_i,
   output logic space_avail_o,
   output logic overflow_o
);

   logic [3:0] prev_ptr;
   logic overflow_seen;
   logic [3:0] next_prev_ptr;
   logic next_overflow_seen;
   logic wrap;

   // ----------------------------------------
   // Overflow tracking
   // ----------------------------------------
   always_comb begin
      wrap = (prev_ptr == STACK_PTR_FULL) && (stack_ptr_i == STACK_PTR_WRAP);
      next_prev_ptr = stack_ptr_i;
      next_overflow_seen = overflow_seen;
      if (device_reset_i) begin
         next_overflow_seen = 1'b0;
      end else if (wrap) begin
         next_overflow_seen = 1'b1;
      end
      // Wrap term covers the cycle before the sticky bit is registered
      space_avail_o = !(overflow_seen || wrap) && (stack_ptr_i != STACK_PTR_FULL);
      overflow_o = overflow_seen;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_ptr <= STACK_PTR_WRAP;
         overflow_seen <= 1'b0;
      end else begin
         prev_ptr <= next_prev_ptr;
         overflow_seen <= next_overflow_seen;
      end
   end

endmodule : stack_space_monitor
`default_nettype wire

/* File: testbench/cpu_status_control_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module cpu_status_control_bench
   import cpu_status_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = BUS_ZERO;
   logic [31:0] rdat;
   logic ack;
   logic [3:0] sp = 4'h0;
   core_event_type ev = '0;
   logic bde = 1'b1;
   logic [7:0] pend = 8'h00;
   logic [7:0] en = 8'h00;
   logic irq;
   logic [7:0] st;
   logic [31:0] rd;
   int mismatches = 0;
   int checks = 0;

   cpu_status_control i_cpu_status_control (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .stack_ptr_i(sp), .core_event_i(ev),
      .brownout_detect_enable_i(bde), .irq_pending_i(pend), .irq_enable_i(en),
      .irq_o(irq), .status_o(st));

   initial begin
      forever #5 clk_i = ~clk_i;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Waits on ack with no bound of its own; the watchdog ends a dead slave
   task bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : bus

   task rdchk(input logic [7:0] exp);
      bus(1'b0, STATUS_ADDR, 4'h0, BUS_ZERO);
      chk(rd, {24'h00_0000, exp});
   endtask : rdchk

   task pulse(input core_event_type e);
      @(posedge clk_i);
      ev <= e;
      @(posedge clk_i);
      ev <= '0;
      repeat (3) @(posedge clk_i);
   endtask : pulse

   task do_reset;
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask : do_reset

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_regs;
      do_reset();
      chk(st, 8'h3D);
      rdchk(8'h3D);
      bus(1'b1, STATUS_ADDR, 4'hF, 32'h0000_00FF);
      rdchk(8'h3F);
      bus(1'b1, STATUS_ADDR, 4'hE, BUS_ZERO);
      rdchk(8'h3F);
      bus(1'b1, STATUS_ADDR, 4'h1, BUS_ZERO);
      rdchk(8'h2C);
      bus(1'b1, 8'h1C, 4'h1, 32'h0000_00FF);
      rdchk(8'h2C);
      bus(1'b0, 8'h1C, 4'h0, BUS_ZERO);
      chk(rd, BUS_ZERO);
      $display("test regs done");
   endtask : t_regs

   task t_events;
      do_reset();
      pulse(5'h08);
      chk(st, 8'h39);
      pulse(5'h04);
      chk(st, 8'h31);
      pulse(5'h10);
      chk(st, 8'h3D);
      pulse(5'h01);
      chk(st, 8'h3C);
      bus(1'b1, STATUS_ADDR, 4'h1, 32'h0000_0003);
      rdchk(8'h2F);
      pulse(5'h02);
      chk(st, 8'h3F);
      bus(1'b1, STATUS_ADDR, 4'h1, 32'h0000_0003);
      // Same-edge write and device reset on the block bit
      fork
         pulse(5'h02);
         bus(1'b1, STATUS_ADDR, 4'h1, 32'h0000_0003);
      join
      repeat (3) @(posedge clk_i);
      chk(st, 8'h3F);
      $display("test events done");
   endtask : t_events

   task t_stack;
      do_reset();
      sp <= 4'hE;
      repeat (3) @(posedge clk_i);
      chk(st, 8'h3D);
      sp <= 4'hF;
      repeat (3) @(posedge clk_i);
      chk(st, 8'h1D);
      sp <= 4'hE;
      repeat (3) @(posedge clk_i);
      chk(st, 8'h3D);
      sp <= 4'hF;
      @(posedge clk_i);
      sp <= 4'h0;
      repeat (3) @(posedge clk_i);
      chk(st, 8'h1D);
      sp <= 4'h3;
      repeat (3) @(posedge clk_i);
      chk(st, 8'h1D);
      pulse(5'h02);
      chk(st, 8'h3D);
      $display("test stack done");
   endtask : t_stack

   task t_irq;
      do_reset();
      pend <= 8'h04;
      en <= 8'h04;
      repeat (3) @(posedge clk_i);
      chk(irq, 1'b0);
      bus(1'b1, STATUS_ADDR, 4'h1, 32'h0000_0003);
      repeat (3) @(posedge clk_i);
      chk(irq, 1'b1);
      en <= 8'h00;
      repeat (3) @(posedge clk_i);
      chk(irq, 1'b0);
      $display("test irq done");
   endtask : t_irq

   task t_brown;
      do_reset();
      pulse(5'h14);
      chk(st, 8'h35);
      // Same-edge write and brown-out reset on the brown-out bit
      fork
         pulse(5'h01);
         bus(1'b1, STATUS_ADDR, 4'h1, 32'h0000_0013);
      join
      chk(st, 8'h36);
      // Detect off: the brown-out bit carries no meaning and is masked
      bde <= 1'b0;
      bus(1'b1, STATUS_ADDR, 4'h1, 32'h0000_0003);
      pulse(5'h01);
      chk(st & 8'hFE, 8'h26);
      pulse(5'h08);
      chk(st & 8'hFE, 8'h2A);
      bde <= 1'b1;
      $display("test brownout done");
   endtask : t_brown

   task give_verdict;
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict

   initial begin
      t_regs();
      t_events();
      t_stack();
      t_irq();
      t_brown();
      give_verdict();
   end

   // Tests need well under 1000 cycles
   initial begin
      #100us;
      mismatches++;
      give_verdict();
   end
endmodule : cpu_status_control_bench
`default_nettype wire
